// [shared/pcflow_pkg.sv]
// constants, op codes and carrier structs for the program flow block
package pcflow_pkg;
   // widths
   localparam int PC_W = 13;
   localparam int OPND_W = 11;
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int DADDR_W = 9;
   localparam int LOC_W = 7;
   localparam int STK_DEPTH = 8;
   localparam int SP_W = 3;
   // register byte offsets on the apb bus
   localparam logic [11:0] OFS_PC_LOW = 12'h000;
   localparam logic [11:0] OFS_LATCH_HIGH = 12'h004;
   localparam logic [11:0] OFS_FSEL_PTR = 12'h008;
   localparam logic [11:0] OFS_BANK_STAT = 12'h00C;
   localparam logic [11:0] OFS_FLOW_STAT = 12'h010;
   // field positions
   localparam int BIT_IND_BANK = 7;
   localparam int BIT_BANK_HI = 6;
   localparam int BIT_BANK_LO = 5;
   localparam int LATCH_FULL_MSB = 4;
   localparam int LATCH_JMP_LSB = 3;
   // reset and fixed values
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
   localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [LOC_W-1:0] LOC_INDIRECT = 7'h00;
   localparam logic [SP_W-1:0] SP_RST = 3'h0;
   localparam logic [SP_W-1:0] SP_ONE = 3'h1;
   localparam logic [31:0] APB_ZERO = 32'h0000_0000;

   // operations that the decoder hands over in the execute stage
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_SUB_JUMP = 3'b001,
      OP_JUMP = 3'b010,
      OP_SUB_EXIT = 3'b011,
      OP_EXIT_LIT = 3'b100,
      OP_IRQ_EXIT = 3'b101,
      OP_IRQ_ENTER = 3'b110,
      OP_PC_LOW_WR = 3'b111
   } flow_op_t;

   // execute-stage request from the decoder
   typedef struct packed {
      logic valid;
      flow_op_t op;
      logic [OPND_W-1:0] operand;
      logic [DATA_W-1:0] data;
   } exec_req_t;

   // data memory access request from the decoder
   typedef struct packed {
      logic valid;
      logic wr;
      logic [LOC_W-1:0] loc;
      logic [DATA_W-1:0] wdata;
   } data_req_t;

   // access issued to the data register file
   typedef struct packed {
      logic re;
      logic we;
      logic [DADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } data_acc_t;
endpackage : pcflow_pkg

// [src/program_counter_stack_indirect.sv]
// program counter, return stack, indirect addressing and fetch stage
// How it works
// - program counter is 13 bits; low byte is a readable, writable register
// - upper counter bits never read or written directly; come from the latch
// - every reset clears the whole program counter to zero
// - writing the low byte loads upper five bits from latch bits 4..0
// - subroutine and plain jumps take top two bits from latch bits 4..3
// - eight deep, 13 bit return stack; its pointer is hidden from software
// - subroutine jump or interrupt entry pushes the program counter
// - subroutine exit, exit with literal and interrupt exit pop the stack
// - pushes and pops leave the latch register untouched
// - stack wraps; ninth push overwrites first, tenth overwrites second
// - no overflow or underflow flag exists; wrapping is silent
// - indirect port has no storage; access goes to the pointed location
// - indirect read of the indirect port itself returns zero
// - indirect write of the indirect port itself stores nothing
// - indirect address is bank select bit above the eight pointer bits
// - two stage fetch and execute; branches cost one flushed cycle
// - 14 bit instruction bus kept apart from the 8 bit data path
`timescale 1ns/1ps
`default_nettype none
module program_counter_stack_indirect
   import pcflow_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // apb register port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // instruction fetch bus
   output logic [pcflow_pkg::PC_W-1:0] fetch_addr,
   input wire logic [pcflow_pkg::INSTR_W-1:0] fetch_word,
   output logic [pcflow_pkg::INSTR_W-1:0] exec_word,
   output logic exec_word_valid,
   // execute stage requests from the decoder
   input wire pcflow_pkg::exec_req_t exec_req,
   input wire pcflow_pkg::data_req_t data_req,
   // data register file side
   output pcflow_pkg::data_acc_t data_acc,
   input wire logic [pcflow_pkg::DATA_W-1:0] data_rdata,
   output logic [pcflow_pkg::DATA_W-1:0] rd_data,
   output logic rd_valid
);
   import pcflow_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [PC_W-1:0] pc_ff, nxt_pc;
   logic [DATA_W-1:0] latch_ff, nxt_latch;
   logic [DATA_W-1:0] fsel_ff, nxt_fsel;
   logic [2:0] bank_ff, nxt_bank;
   logic [SP_W-1:0] sp_ff, nxt_sp;
   logic [PC_W-1:0] stack_ff [STK_DEPTH];
   logic push_en;
   logic [INSTR_W-1:0] word_ff, nxt_word;
   logic valid_ff, nxt_valid;
   logic branch;
   data_acc_t acc_ff, nxt_acc;
   logic zero_ff, nxt_zero;
   logic rsel_ff, nxt_rsel;
   logic [DATA_W-1:0] rd_ff, nxt_rd;
   logic rv_ff, nxt_rv;
   logic apb_wr, apb_rd, mapped;
   logic [31:0] rdmux;

   ////////////////////////////////////////////////////////////////////////
   // apb decode; every access completes with no wait states
   always_comb begin
      apb_wr = psel && penable && pwrite;
      apb_rd = psel && !pwrite;
      mapped = (paddr == OFS_PC_LOW) || (paddr == OFS_LATCH_HIGH) ||
               (paddr == OFS_FSEL_PTR) || (paddr == OFS_BANK_STAT) ||
               (paddr == OFS_FLOW_STAT);
      rdmux = APB_ZERO;
      case (paddr)
         OFS_PC_LOW: rdmux = {24'h00_0000, pc_ff[DATA_W-1:0]};
         OFS_LATCH_HIGH: rdmux = {24'h00_0000, latch_ff};
         OFS_FSEL_PTR: rdmux = {24'h00_0000, fsel_ff};
         OFS_BANK_STAT: rdmux = {24'h00_0000, bank_ff, 5'h00};
         OFS_FLOW_STAT: rdmux = {31'h0000_0000, valid_ff};
         default: rdmux = APB_ZERO;
      endcase
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = (apb_rd && mapped) ? rdmux : APB_ZERO;

   ////////////////////////////////////////////////////////////////////////
   // program counter and return stack next state
   always_comb begin
      nxt_pc = pc_ff + PC_ONE;
      nxt_sp = sp_ff;
      push_en = 1'b0;
      branch = 1'b0;
      if (exec_req.valid) begin
         case (exec_req.op)
            OP_SUB_JUMP: begin
               push_en = 1'b1;
               nxt_sp = sp_ff + SP_ONE;
               nxt_pc = {latch_ff[LATCH_FULL_MSB:LATCH_JMP_LSB],
                         exec_req.operand};
               branch = 1'b1;
            end
            OP_JUMP: begin
               nxt_pc = {latch_ff[LATCH_FULL_MSB:LATCH_JMP_LSB],
                         exec_req.operand};
               branch = 1'b1;
            end
            OP_SUB_EXIT, OP_EXIT_LIT, OP_IRQ_EXIT: begin
               nxt_sp = sp_ff - SP_ONE;
               nxt_pc = stack_ff[sp_ff - SP_ONE];
               branch = 1'b1;
            end
            OP_IRQ_ENTER: begin
               push_en = 1'b1;
               nxt_sp = sp_ff + SP_ONE;
               nxt_pc = IRQ_VECTOR;
               branch = 1'b1;
            end
            OP_PC_LOW_WR: begin
               nxt_pc = {latch_ff[LATCH_FULL_MSB:0], exec_req.data};
               branch = 1'b1;
            end
            default: begin
               branch = 1'b0;
            end
         endcase
      end else if (apb_wr && paddr == OFS_PC_LOW) begin
         nxt_pc = {latch_ff[LATCH_FULL_MSB:0], pwdata[DATA_W-1:0]};
         branch = 1'b1;
      end
   end

   // counter and stack registers; stack contents cleared with the rest
   always_ff @(posedge mclk) begin
      if (srst) begin
         pc_ff <= PC_RST;
         sp_ff <= SP_RST;
         for (int i = 0; i < STK_DEPTH; i++) begin
            stack_ff[i] <= PC_RST;
         end
      end else begin
         pc_ff <= nxt_pc;
         sp_ff <= nxt_sp;
         if (push_en) begin
            stack_ff[sp_ff] <= pc_ff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software registers: latch, pointer and bank bits; only apb writes
   always_comb begin
      nxt_latch = latch_ff;
      nxt_fsel = fsel_ff;
      nxt_bank = bank_ff;
      if (apb_wr) begin
         case (paddr)
            OFS_LATCH_HIGH: nxt_latch = pwdata[DATA_W-1:0];
            OFS_FSEL_PTR: nxt_fsel = pwdata[DATA_W-1:0];
            OFS_BANK_STAT: nxt_bank = pwdata[BIT_IND_BANK:BIT_BANK_LO];
            default: nxt_latch = latch_ff;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         latch_ff <= BYTE_ZERO;
         fsel_ff <= BYTE_ZERO;
         bank_ff <= 3'h0;
      end else begin
         latch_ff <= nxt_latch;
         fsel_ff <= nxt_fsel;
         bank_ff <= nxt_bank;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fetch stage; a branch discards the word already fetched
   always_comb begin
      nxt_word = fetch_word;
      nxt_valid = !branch;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         word_ff <= 14'h0000;
         valid_ff <= 1'b0;
      end else begin
         word_ff <= nxt_word;
         valid_ff <= nxt_valid;
      end
   end

   assign fetch_addr = pc_ff;
   assign exec_word = word_ff;
   assign exec_word_valid = valid_ff;

   ////////////////////////////////////////////////////////////////////////
   // data address forming and indirect port handling
   logic ind_sel, self_sel;
   logic [DADDR_W-1:0] ind_addr, dir_addr;
   always_comb begin
      ind_sel = (data_req.loc == LOC_INDIRECT);
      ind_addr = {bank_ff[2], fsel_ff};
      dir_addr = {bank_ff[1:0], data_req.loc};
      self_sel = ind_sel && (fsel_ff[LOC_W-1:0] == LOC_INDIRECT);
      nxt_acc.addr = ind_sel ? ind_addr : dir_addr;
      nxt_acc.wdata = data_req.wdata;
      nxt_acc.we = data_req.valid && data_req.wr && !self_sel;
      nxt_acc.re = data_req.valid && !data_req.wr && !self_sel;
      nxt_zero = self_sel;
      nxt_rsel = data_req.valid && !data_req.wr;
      nxt_rd = zero_ff ? BYTE_ZERO : data_rdata;
      nxt_rv = rsel_ff;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         acc_ff <= '0;
         zero_ff <= 1'b0;
         rsel_ff <= 1'b0;
         rd_ff <= BYTE_ZERO;
         rv_ff <= 1'b0;
      end else begin
         acc_ff <= nxt_acc;
         zero_ff <= nxt_zero;
         rsel_ff <= nxt_rsel;
         rd_ff <= nxt_rd;
         rv_ff <= nxt_rv;
      end
   end

   assign data_acc = acc_ff;
   assign rd_data = rd_ff;
   assign rd_valid = rv_ff;

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_reset_clears_pc: assert property (@(posedge mclk)
      srst |=> (pc_ff == PC_RST))
      else $error("pc not zero after reset");

   a_pcl_write_load: assert property (@(posedge mclk) disable iff (srst)
      (exec_req.valid && exec_req.op == OP_PC_LOW_WR) |=>
      (pc_ff == {$past(latch_ff[4:0]), $past(exec_req.data)}))
      else $error("low byte write loaded wrong counter");

   a_jump_target: assert property (@(posedge mclk) disable iff (srst)
      (exec_req.valid && exec_req.op inside {OP_JUMP, OP_SUB_JUMP}) |=>
      (pc_ff == {$past(latch_ff[4:3]), $past(exec_req.operand)}))
      else $error("jump target wrong");

   a_call_return_pair: assert property (@(posedge mclk)
      disable iff (srst)
      (exec_req.valid && exec_req.op == OP_SUB_JUMP) ##2
      (exec_req.valid && exec_req.op == OP_SUB_EXIT) |=>
      (pc_ff == $past(pc_ff, 3)))
      else $error("return did not restore pushed counter");

   a_irq_push_vector: assert property (@(posedge mclk)
      disable iff (srst)
      (exec_req.valid && exec_req.op == OP_IRQ_ENTER) |=>
      (pc_ff == IRQ_VECTOR) && (stack_ff[$past(sp_ff)] == $past(pc_ff)))
      else $error("interrupt entry push or vector wrong");

   a_latch_kept_stack: assert property (@(posedge mclk)
      disable iff (srst)
      (exec_req.valid && !(apb_wr && paddr == OFS_LATCH_HIGH)) |=>
      $stable(latch_ff))
      else $error("latch changed by flow operation");

   a_stack_wraps: assert property (@(posedge mclk) disable iff (srst)
      (sp_ff == 3'h7 && exec_req.valid && exec_req.op == OP_SUB_JUMP)
      |=> (sp_ff == 3'h0))
      else $error("stack pointer did not wrap");

   a_self_read_zero: assert property (@(posedge mclk) disable iff (srst)
      (data_req.valid && !data_req.wr && data_req.loc == LOC_INDIRECT &&
      fsel_ff[6:0] == LOC_INDIRECT) |=> ##1 rd_valid && rd_data == 8'h00)
      else $error("indirect self read not zero");

   a_self_write_none: assert property (@(posedge mclk) disable iff (srst)
      (data_req.valid && data_req.loc == LOC_INDIRECT &&
      fsel_ff[6:0] == LOC_INDIRECT) |=> !data_acc.we && !data_acc.re)
      else $error("indirect self access reached memory");

   a_indirect_addr: assert property (@(posedge mclk) disable iff (srst)
      (data_req.valid && data_req.loc == LOC_INDIRECT) |=>
      data_acc.addr == {$past(bank_ff[2]), $past(fsel_ff)})
      else $error("indirect address wrong");

   a_direct_addr: assert property (@(posedge mclk) disable iff (srst)
      (data_req.valid && data_req.loc != LOC_INDIRECT) |=>
      data_acc.addr == {$past(bank_ff[1:0]), $past(data_req.loc)})
      else $error("direct address wrong");

   a_branch_flush: assert property (@(posedge mclk) disable iff (srst)
      (exec_req.valid && exec_req.op != OP_NONE) |=> !exec_word_valid
      ##1 (exec_word_valid || $past(branch)))
      else $error("branch did not flush exactly one slot");

   a_seq_fetch: assert property (@(posedge mclk) disable iff (srst)
      (!branch) |=> pc_ff == $past(pc_ff) + 13'h0001)
      else $error("counter did not advance");
endmodule : program_counter_stack_indirect
`default_nettype wire

// [verif/pcflow_partner.sv]
// decoder-side model: instruction store and data register file
`timescale 1ns/1ps
`default_nettype none
module pcflow_partner (
   // clock
   input wire logic mclk,
   // fetch bus
   input wire logic [pcflow_pkg::PC_W-1:0] fetch_addr,
   output logic [pcflow_pkg::INSTR_W-1:0] fetch_word,
   // data file
   input wire pcflow_pkg::data_acc_t data_acc,
   output logic [pcflow_pkg::DATA_W-1:0] data_rdata
);
   import pcflow_pkg::*;
   logic [DATA_W-1:0] mem [0:511];
   logic [DATA_W-1:0] last = 8'h00;
   // fixed word pattern per address on the separate fetch bus
   assign fetch_word = {1'b0, fetch_addr} ^ 14'h1555;
   // read data only while selected, else a toggling pattern
   assign data_rdata = data_acc.re ? mem[data_acc.addr] : ~last;
   // preset contents follow the address
   initial begin
      for (int i = 0; i < 512; i++) begin
         mem[i] = i[7:0] ^ 8'h5A;
      end
   end
   // writes land at the edge
   always @(posedge mclk) begin
      last <= data_rdata;
      if (data_acc.we) begin
         mem[data_acc.addr] <= data_acc.wdata;
      end
   end
endmodule : pcflow_partner
`default_nettype wire

// [verif/program_counter_stack_indirect_tb.sv]
// self-checking bench for the program flow block
`timescale 1ns/1ps
`default_nettype none
module program_counter_stack_indirect_tb;
   import pcflow_pkg::*;
   logic mclk, srst, psel, penable, pwrite, pready, pslverr, serr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv, rv;
   logic [PC_W-1:0] fetch_addr, pre, post;
   logic [PC_W-1:0] q [0:9];
   logic [INSTR_W-1:0] fetch_word, exec_word;
   logic exec_word_valid, rd_valid;
   exec_req_t exec_req;
   data_req_t data_req;
   data_acc_t data_acc;
   logic [DATA_W-1:0] data_rdata, rd_data, lat, bnk, file_select_pointer;
   logic [10:0] opd;
   logic [8:0] ea, ia;
   logic [15:0] seed;
   int error_cnt, compares;
   program_counter_stack_indirect dut_u (.mclk(mclk), .srst(srst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fetch_addr(fetch_addr),
      .fetch_word(fetch_word), .exec_word(exec_word),
      .exec_word_valid(exec_word_valid), .exec_req(exec_req),
      .data_req(data_req), .data_acc(data_acc),
      .data_rdata(data_rdata), .rd_data(rd_data), .rd_valid(rd_valid));
   pcflow_partner far_u (.mclk(mclk), .fetch_addr(fetch_addr),
      .fetch_word(fetch_word), .data_acc(data_acc),
      .data_rdata(data_rdata));
   ////////////////////////////////////////
   // clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // lfsr source of random values
   function automatic logic [31:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return {16'h0000, seed};
   endfunction : rnd
   // compare and count
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // one apb transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rdv = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask : apb
   // one execute op; pre is the pc in its slot, post the pc after
   task automatic ex(input flow_op_t o, input logic [10:0] a,
         input logic [7:0] d);
      @(posedge mclk);
      exec_req <= '{1'b1, o, a, d};
      #1 pre = fetch_addr;
      @(posedge mclk);
      exec_req <= '0;
      #1 post = fetch_addr;
      chk(exec_word_valid, 1'b0);
   endtask : ex
   // one data access with expected address, enable and read result
   task automatic dx(input logic w, input logic [6:0] l,
         input logic [7:0] v, input logic [8:0] a, input logic en,
         input logic [7:0] er);
      @(posedge mclk);
      data_req <= '{1'b1, w, l, v};
      @(posedge mclk);
      data_req <= '0;
      #1 chk(data_acc.re, en & ~w);
      chk(data_acc.we, en & w);
      if (en) chk(data_acc.addr, a);
      @(posedge mclk);
      #1 if (!w) chk({rd_valid, rd_data}, {1'b1, er});
   endtask : dx
   ////////////////////////////////////////
   // main sequence
   initial begin
      {srst, psel, penable, pwrite, paddr, pwdata} = '0;
      srst = 1'b1;
      exec_req = '0;
      data_req = '0;
      seed = 16'hA267;
      repeat (15) @(posedge mclk);
      #1 chk(fetch_addr, PC_RST);
      @(posedge mclk);
      srst <= 1'b0;
      // low byte writes over apb and from the decoder
      for (int k = 0; k < 2; k++) begin
         rv = rnd();
         lat = k ? rv[7:0] : 8'hE7;
         apb(1'b1, OFS_LATCH_HIGH, {24'h00_0000, lat});
         apb(1'b1, OFS_PC_LOW, 32'h0000_00A5);
         #1 chk(fetch_addr, {lat[4:0], 8'hA5});
         ex(OP_PC_LOW_WR, 11'h000, rv[15:8]);
         chk(post, {lat[4:0], rv[15:8]});
      end
      // jumps, corner operand and random ones
      for (int k = 0; k < 4; k++) begin
         rv = rnd();
         opd = k[0] ? rv[10:0] : 11'h7FF;
         ex(k[1] ? OP_JUMP : OP_SUB_JUMP, opd, 8'h00);
         chk(post, {lat[4:3], opd});
      end
      @(posedge mclk);
      #1 chk(exec_word_valid, 1'b1);
      chk(exec_word, {1'b0, post} ^ 14'h1555);
      // ten pushes then nine pops wrap the ring
      for (int k = 0; k < 10; k++) begin
         rv = rnd();
         ex(k == 4 ? OP_IRQ_ENTER : OP_SUB_JUMP, rv[10:0], 8'h00);
         q[k] = pre;
         if (k == 4) chk(post, IRQ_VECTOR);
      end
      for (int k = 0; k < 9; k++) begin
         ex(flow_op_t'(3 + k % 3), 11'h000, 8'h00);
         chk(post, q[k < 8 ? 9 - k : 9]);
      end
      apb(1'b0, OFS_LATCH_HIGH, APB_ZERO);
      chk(rdv[4:0], lat[4:0]);
      // direct and indirect data access
      rv = rnd();
      bnk = rv[7:0];
      file_select_pointer = rv[15:8] | 8'h01;
      apb(1'b1, OFS_BANK_STAT, {24'h00_0000, bnk});
      apb(1'b1, OFS_FSEL_PTR, {24'h00_0000, file_select_pointer});
      rv = rnd();
      ea = {bnk[6:5], rv[6:0] | 7'h01};
      ia = {bnk[7], file_select_pointer};
      dx(1'b0, ea[6:0], 8'h00, ea, 1'b1, ea[7:0] ^ 8'h5A);
      dx(1'b0, LOC_INDIRECT, 8'h00, ia, 1'b1, ia[7:0] ^ 8'h5A);
      dx(1'b1, ea[6:0], rv[15:8], ea, 1'b1, 8'h00);
      dx(1'b0, ea[6:0], 8'h00, ea, 1'b1, rv[15:8]);
      // pointer aimed at the indirect port itself
      apb(1'b1, OFS_FSEL_PTR, {24'h00_0000, file_select_pointer[7], 7'h00});
      dx(1'b0, LOC_INDIRECT, 8'h00, ia, 1'b0, BYTE_ZERO);
      dx(1'b1, LOC_INDIRECT, 8'h3C, ia, 1'b0, BYTE_ZERO);
      apb(1'b0, 12'h014, APB_ZERO);
      chk({serr, rdv}, {1'b1, APB_ZERO});
      // reset in mid-run, then a silent pop of the cleared stack
      @(posedge mclk);
      srst <= 1'b1;
      @(posedge mclk);
      #1 chk(fetch_addr, PC_RST);
      @(posedge mclk);
      srst <= 1'b0;
      ex(OP_SUB_EXIT, 11'h000, 8'h00);
      chk(post, PC_RST);
      tally_and_finish();
   end
endmodule : program_counter_stack_indirect_tb
`default_nettype wire
